/* shared/rcap_consts.vh */
// offsets, field positions and reset values for the remote capability register
`ifndef RCAP_CONSTS_VH
`define RCAP_CONSTS_VH
`define RCAP_ADDR_CAP1     8'h20
`define RCAP_ADDR_CAP2     8'h21
`define RCAP_CAP1_RESET    8'h00
`define RCAP_CAP2_RESET    2'h0
`define RCAP_BIT_HOLD      7
`define RCAP_BIT_CODE0     6
`define RCAP_BIT_FREQ      5
`define RCAP_BIT_EQ        4
`define RCAP_BIT_TWO_LANE  3
`define RCAP_BIT_ROLE      2
`define RCAP_MODE_NORMAL   3'h0
`define RCAP_MODE_HS1      3'h1
`define RCAP_MODE_HS2      3'h2
`define RCAP_MODE_HS4      3'h3
`endif

/* rtl/rcap_port_store.v */
// capability storage for one link port
`timescale 1ns/1ps
`default_nettype none
`include "rcap_consts.vh"
module rcap_port_store (
  // clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       clk_en,
  // software write
  input  wire       sw_wr1,
  input  wire       sw_wr2,
  input  wire [7:0] sw_wdata,
  // control channel load
  input  wire       cc_load,
  input  wire [5:0] cc_cap1,
  input  wire [1:0] cc_cap2,
  // stored values
  output reg  [7:0] cap1,
  output reg  [1:0] cap2
);
  wire hold = cap1[`RCAP_BIT_HOLD];

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cap1 <= `RCAP_CAP1_RESET;
      cap2 <= `RCAP_CAP2_RESET;
    end else if (clk_en) begin
      // software write wins over an auto load in the same cycle
      if (sw_wr1) begin
        cap1 <= {sw_wdata[7:2], 2'h0}; // RULE2
      end else if (cc_load && !hold) begin // RULE1
        // top bit of the channel word is dropped: hold is never auto-loaded
        cap1 <= {1'b0, cc_cap1[4:0], 2'h0}; // RULE4
      end
      if (sw_wr2) begin
        cap2 <= sw_wdata[1:0]; // RULE2
      end else if (cc_load && !hold && !sw_wr1) begin // RULE1
        cap2 <= cc_cap2; // RULE4
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/rcap_top.v */
// remote capability register bank, two ports, register access and decode
//
// How it works
// RULE1 - hold bit stops control channel reloads
// RULE2 - held values are last written ones
// RULE3 - bit six is mode code lsb
// RULE4 - after lock, load fields from channel
// RULE5 - software writing fields must set hold; code keeps written bit seven, so writing it clear leaves reloads on
// RULE6 - bit five requests frequency training pattern
// RULE7 - bit four requests equalisation pattern, reset zero
// RULE8 - bit three reports two lane capability
// RULE9 - bit two gives primary/secondary channel role
// RULE10 - port select reaches port one copy
// RULE11 - select ignored when secondary address enabled
// RULE12 - decode three bit control channel mode
// RULE13 - independent storage and hold per port
`timescale 1ns/1ps
`default_nettype none
`include "rcap_consts.vh"
module rcap_top (
  // clock and reset
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       clk_en,
  // register access from the register logic
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_via_secondary,
  input  wire       second_port_select,
  input  wire       secondary_address_enable,
  output reg  [7:0] reg_rdata,
  // receiver lock pins and control channel capability words
  input  wire       rx_lock0_pin,
  input  wire       rx_lock1_pin,
  input  wire       cc_valid0,
  input  wire [5:0] cc_cap1_0,
  input  wire [1:0] cc_cap2_0,
  input  wire       cc_valid1,
  input  wire [5:0] cc_cap1_1,
  input  wire [1:0] cc_cap2_1,
  // capabilities in use, port 0
  output reg  [2:0] fast_control_channel_code0,
  output reg        frequency_training_request0,
  output reg        equalisation_training_request0,
  output reg        two_lane_capable0,
  output reg        channel_role0,
  output reg  [1:0] gpio_lines0,
  // capabilities in use, port 1
  output reg  [2:0] fast_control_channel_code1,
  output reg        frequency_training_request1,
  output reg        equalisation_training_request1,
  output reg        two_lane_capable1,
  output reg        channel_role1,
  output reg  [1:0] gpio_lines1
);
  // lock comes from the link side, synchronise before use
  reg  [1:0] lock_meta;
  reg  [1:0] lock_sync;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lock_meta <= 2'h0;
      lock_sync <= 2'h0;
    end else if (clk_en) begin
      lock_meta <= {rx_lock1_pin, rx_lock0_pin};
      lock_sync <= lock_meta;
    end
  end

  // port one reached by the secondary address, or by select when that address is off
  wire to_port1 = secondary_address_enable ? reg_via_secondary
                                           : second_port_select; // RULE10 RULE11
  wire wr1 = reg_wr && (reg_addr == `RCAP_ADDR_CAP1);
  wire wr2 = reg_wr && (reg_addr == `RCAP_ADDR_CAP2);

  wire [7:0] cap1_p0;
  wire [1:0] cap2_p0;
  wire [7:0] cap1_p1;
  wire [1:0] cap2_p1;

  rcap_port_store u_port0 (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .sw_wr1   (wr1 && !to_port1), // RULE13
    .sw_wr2   (wr2 && !to_port1),
    .sw_wdata (reg_wdata),
    .cc_load  (cc_valid0 && lock_sync[0]), // RULE4
    .cc_cap1  (cc_cap1_0),
    .cc_cap2  (cc_cap2_0),
    .cap1     (cap1_p0),
    .cap2     (cap2_p0)
  );

  rcap_port_store u_port1 (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .sw_wr1   (wr1 && to_port1), // RULE13
    .sw_wr2   (wr2 && to_port1),
    .sw_wdata (reg_wdata),
    .cc_load  (cc_valid1 && lock_sync[1]), // RULE4
    .cc_cap1  (cc_cap1_1),
    .cc_cap2  (cc_cap2_1),
    .cap1     (cap1_p1),
    .cap2     (cap2_p1)
  );

  // number of high speed gpio lines as log2 plus one (1, 2, 3 for HS1, HS2, HS4); 0 means normal frame or an unused code 4 to 7
  function [1:0] mode_lines;
    input [2:0] code;
    begin
      case (code)
        `RCAP_MODE_HS1: mode_lines = 2'h1; // RULE12
        `RCAP_MODE_HS2: mode_lines = 2'h2; // RULE12
        `RCAP_MODE_HS4: mode_lines = 2'h3; // RULE12
        default:        mode_lines = 2'h0;
      endcase
    end
  endfunction

  wire [7:0] sel_cap1 = to_port1 ? cap1_p1 : cap1_p0; // RULE10
  wire [1:0] sel_cap2 = to_port1 ? cap2_p1 : cap2_p0;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      fast_control_channel_code0     <= 3'h0;
      frequency_training_request0    <= 1'b0;
      equalisation_training_request0 <= 1'b0;
      two_lane_capable0              <= 1'b0;
      channel_role0                  <= 1'b0;
      gpio_lines0                    <= 2'h0;
      fast_control_channel_code1     <= 3'h0;
      frequency_training_request1    <= 1'b0;
      equalisation_training_request1 <= 1'b0;
      two_lane_capable1              <= 1'b0;
      channel_role1                  <= 1'b0;
      gpio_lines1                    <= 2'h0;
    end else if (clk_en) begin
      // unmapped addresses read zero; reserved cap2 bits read zero
      if (reg_rd) begin
        if (reg_addr == `RCAP_ADDR_CAP1) begin
          reg_rdata <= sel_cap1;
        end else if (reg_addr == `RCAP_ADDR_CAP2) begin
          reg_rdata <= {6'h00, sel_cap2};
        end else begin
          reg_rdata <= 8'h00;
        end
      end
      fast_control_channel_code0     <= {cap2_p0, cap1_p0[`RCAP_BIT_CODE0]}; // RULE3
      frequency_training_request0    <= cap1_p0[`RCAP_BIT_FREQ]; // RULE6
      equalisation_training_request0 <= cap1_p0[`RCAP_BIT_EQ]; // RULE7
      two_lane_capable0              <= cap1_p0[`RCAP_BIT_TWO_LANE]; // RULE8
      channel_role0                  <= cap1_p0[`RCAP_BIT_ROLE]; // RULE9
      gpio_lines0                    <= mode_lines({cap2_p0, cap1_p0[`RCAP_BIT_CODE0]});
      fast_control_channel_code1     <= {cap2_p1, cap1_p1[`RCAP_BIT_CODE0]}; // RULE3
      frequency_training_request1    <= cap1_p1[`RCAP_BIT_FREQ]; // RULE6
      equalisation_training_request1 <= cap1_p1[`RCAP_BIT_EQ]; // RULE7
      two_lane_capable1              <= cap1_p1[`RCAP_BIT_TWO_LANE]; // RULE8
      channel_role1                  <= cap1_p1[`RCAP_BIT_ROLE]; // RULE9
      gpio_lines1                    <= mode_lines({cap2_p1, cap1_p1[`RCAP_BIT_CODE0]});
    end
  end
endmodule
`default_nettype wire

/* testbench/rcap_props.sv */
// port assertions for the remote capability register bank
`timescale 1ns/1ps
`default_nettype none
module rcap_props (
  // clock, reset, register access
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_via_secondary,
  input wire logic       second_port_select,
  input wire logic       secondary_address_enable,
  // channel and outputs
  input wire logic       rx_lock0_pin,
  input wire logic       cc_valid0,
  input wire logic [5:0] cc_cap1_0,
  input wire logic [2:0] fast_control_channel_code0,
  input wire logic [2:0] fast_control_channel_code1,
  input wire logic       frequency_training_request0,
  input wire logic [1:0] gpio_lines0
);
  logic p1, w0, w1, hold0;
  assign p1 = secondary_address_enable ? reg_via_secondary : second_port_select;
  assign w0 = clk_en && reg_wr && reg_addr == 8'h20 && !p1;
  assign w1 = clk_en && reg_wr && reg_addr == 8'h20 && p1;
  // hold is only ever written by software, so writes alone track it
  always @(posedge core_clk or negedge nrst)
    if (!nrst) hold0 <= 1'b0;
    else if (w0) hold0 <= reg_wdata[7];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_code_lsb_wr: assert property (w0 ##1 clk_en |=>
    fast_control_channel_code0[0] == $past(reg_wdata[6], 2)) else $error("code lsb");
  chk_freq_wr: assert property (w0 ##1 clk_en |=>
    frequency_training_request0 == $past(reg_wdata[5], 2)) else $error("freq write");
  chk_port_one_wr: assert property (w1 ##1 clk_en |=>
    fast_control_channel_code1[0] == $past(reg_wdata[6], 2)) else $error("port one");
  chk_hold_blocks: assert property ((hold0 && !w0)[*3] |->
    $stable(frequency_training_request0)) else $error("hold");
  chk_load_taken: assert property ((rx_lock0_pin && clk_en)[*4] ##0
    (cc_valid0 && !hold0 && !w0) ##1 clk_en |=>
    frequency_training_request0 == $past(cc_cap1_0[3], 2)) else $error("load");
  chk_load_lsb: assert property ((rx_lock0_pin && clk_en)[*4] ##0
    (cc_valid0 && !hold0 && !w0) ##1 clk_en |=>
    fast_control_channel_code0[0] == $past(cc_cap1_0[4], 2)) else $error("load lsb");
  chk_port_apart: assert property ((!w0 && !cc_valid0)[*3] |->
    $stable(frequency_training_request0)) else $error("isolation");
  chk_mode_decode: assert property (gpio_lines0 ==
    (fast_control_channel_code0[2] ? 2'h0 : fast_control_channel_code0[1:0])) else $error("decode");
endmodule
bind rcap_top rcap_props u_chk (.*);
`default_nettype wire

/* testbench/rcap_partner.sv */
// remote receiver model sending its capability word over the back channel
`timescale 1ns/1ps
`default_nettype none
module rcap_partner (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [7:0] word,
  output logic            lock,
  output logic            valid,
  output logic [7:0]      cap
);
  initial {lock, valid, cap} = 10'h0;
  // word lines toggle between sends so a stale word cannot pass
  always @(negedge core_clk) begin
    lock  <= 1'b1;
    valid <= go;
    cap   <= go ? word : ~cap;
  end
endmodule
`default_nettype wire

/* testbench/remote_capability_register_tb.sv */
// self-checking bench for the remote capability register bank
`timescale 1ns/1ps
`default_nettype none
module remote_capability_register_tb;
  logic core_clk, nrst, reg_wr, reg_rd, reg_via_secondary, second_port_select;
  logic secondary_address_enable, go, lock, valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cap, seed;
  logic [2:0] fast_control_channel_code0, fast_control_channel_code1;
  logic [1:0] gpio_lines0, gpio_lines1;
  logic frequency_training_request0, frequency_training_request1, channel_role0, channel_role1;
  logic equalisation_training_request0, equalisation_training_request1;
  logic two_lane_capable0, two_lane_capable1;
  logic [7:0] expq[$];
  int miscompares, checks_done;
  rcap_partner rp (.core_clk(core_clk), .go(go), .word(seed), .lock(lock), .valid(valid), .cap(cap));
  rcap_top uut (.*, .clk_en(1'b1), .rx_lock0_pin(lock), .rx_lock1_pin(1'b0), .cc_valid0(valid),
    .cc_cap1_0(cap[5:0]), .cc_cap2_0(cap[7:6]), .cc_valid1(1'b0), .cc_cap1_1(6'h0), .cc_cap2_1(2'h0));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one access; a read notes its expected data for the monitor
  task automatic acc(input logic w, input logic [7:0] a, d, input logic [2:0] p);
    @(negedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    {secondary_address_enable, reg_via_secondary, second_port_select} = p;
    if (!w) expq.push_back(d);
    @(negedge core_clk);
    {reg_wr, reg_rd} = 2'h0;
  endtask
  task automatic send;
    @(negedge core_clk);
    seed = lfsr(seed);
    go <= 1'b1;
    @(negedge core_clk);
    go <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) if (reg_rd) begin
    @(negedge core_clk);
    chk("rdata", reg_rdata, expq.pop_front());
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
  initial begin
    {nrst, reg_wr, reg_rd, go, reg_addr, reg_wdata} = 20'h0;
    {secondary_address_enable, reg_via_secondary, second_port_select} = 3'h0;
    seed = 8'h4e;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'b1;
    acc(0, 8'h20, 8'h00, 3'b000);
    acc(0, 8'h21, 8'h00, 3'b001);
    acc(1, 8'h22, 8'hff, 3'b000);
    acc(0, 8'h22, 8'h00, 3'b000);
    $display("test 1 done");
    send;
    acc(0, 8'h20, {1'b0, seed[4:0], 2'h0}, 3'b000);
    acc(0, 8'h21, {6'h0, seed[7:6]}, 3'b000);
    acc(0, 8'h20, 8'h00, 3'b001);
    chk("freq0", frequency_training_request0, seed[3]);
    chk("code0", fast_control_channel_code0, {seed[7:6], seed[4]});
    $display("test 2 done");
    acc(1, 8'h20, 8'hbc, 3'b101);
    send;
    acc(0, 8'h20, 8'hbc, 3'b000);
    acc(0, 8'h20, 8'h00, 3'b110);
    chk("eq0", equalisation_training_request0, 8'h01);
    chk("lane0", two_lane_capable0, 8'h01);
    chk("role0", channel_role0, 8'h01);
    $display("test 3 done");
    for (int c = 0; c < 8; c++) begin
      acc(1, 8'h21, {6'h0, c[2:1]}, 3'b001);
      acc(1, 8'h20, {1'b1, c[0], 6'h0}, 3'b001);
      @(negedge core_clk);
      chk("code1", fast_control_channel_code1, c[2:0]);
      chk("gpio1", gpio_lines1, c[2] ? 2'h0 : c[1:0]);
    end
    $display("test 4 done");
    repeat (2) @(negedge core_clk);
    stop_test;
  end
endmodule
`default_nettype wire
